// [logic/acq_roi_pkg.sv]
// shared constants and types for the acquisition window and roi block
package acq_roi_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;
  localparam logic [7:0] FRAMES_OFS      = 8'h08;
  localparam logic [7:0] WIN_PX_OFS      = 8'h0c;
  localparam logic [7:0] WIN_LN_OFS      = 8'h10;
  localparam logic [7:0] ROI_PX_OFS      = 8'h14;
  localparam logic [7:0] ROI_LN_OFS      = 8'h18;
  localparam logic [7:0] TRIG_CFG_OFS    = 8'h1c;
  localparam logic [7:0] TRIG_DRIVE_OFS  = 8'h20;
  localparam logic [7:0] PULSE_DELAY_OFS = 8'h24;
  localparam logic [7:0] PULSE_HIGH_OFS  = 8'h28;
  localparam logic [7:0] PULSE_LOW_OFS   = 8'h2c;
  localparam logic [7:0] PULSE_COUNT_OFS = 8'h30;

  // control register bits
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_STOP_BIT    = 1;
  localparam int CTRL_TRIG_EN_BIT = 2;
  localparam int CTRL_PULSE_BIT   = 3;

  // status register fields
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_PULSE_BIT   = 1;
  localparam int STAT_FRAMES_LSB  = 16;

  // trigger register field positions (eight lines)
  localparam int TRIG_LINES       = 8;
  localparam int TRIG_FALL_LSB    = 8;
  localparam int DRIVE_PULSE_LSB  = 8;
  localparam int DRIVE_LEVEL_LSB  = 16;

  // reset values
  localparam logic [15:0] FRAMES_RST  = 16'h0001;
  localparam logic [31:0] WINDOW_RST  = 32'hffff_0000;
  localparam logic [31:0] PULSE_RST   = 32'h0000_0001;

  // start and count of one dimension
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] start;
  } window_t;

  // window and nested roi, both dimensions
  typedef struct packed {
    window_t win_px;
    window_t win_ln;
    window_t roi_px;
    window_t roi_ln;
  } acq_cfg_t;

  // camera enables as sampled on the link clock
  typedef struct packed {
    logic fval;
    logic lval;
    logic dval;
  } cam_enables_t;

  typedef enum logic [1:0] {P_IDLE, P_DELAY, P_HIGH, P_LOW} pulse_state_t;

endpackage : acq_roi_pkg

// [logic/acq_roi.sv]
// acquisition window, roi selection, start control and pulse timing
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// (RL1) Only pixels inside the active region reach the tap reorder stream output.
// (RL2) A first pixel and pixel count per line are counted from the rising line enable.
// (RL3) A first line and line count per frame are counted from the rising frame enable.
// (RL4) A nested roi start and count per dimension keeps a subset of the window.
// (RL5) Roi selection applies to every line of every frame.
// (RL6) Only roi pixels are forwarded toward host memory, so a smaller roi moves less data.
// (RL7) A software start captures the programmed number of frames, then ends; a frame count of zero runs until stop.
// (RL8) With trigger start enabled, an external or system trigger line starts acquisition.
// (RL9) Each trigger line starts on its own chosen rising or falling edge.
// (RL10) Counter timing makes single pulses or pulse trains, routable to any trigger line.
// (RL11) Selected data streams continuously to the scatter gather dma path.
// (RL12) Counts that run past the line or frame enable end at its fall and never wrap.
module acq_roi
  import acq_roi_pkg::*;
#(
  parameter int TAP_BITS = 64
)(
  // apb slave
  input  wire  logic                  pclk,
  input  wire  logic                  presetn,
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  logic [7:0]            paddr,
  input  wire  logic [31:0]           pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // trigger lines, two way
  input  wire  logic [TRIG_LINES-1:0] trig_in,
  output logic [TRIG_LINES-1:0]       trig_out,
  output logic [TRIG_LINES-1:0]       trig_oe,
  // camera link side
  input  wire  logic                  link_clk,
  input  wire  cam_enables_t          cam_en,
  input  wire  logic [TAP_BITS-1:0]   cam_data,
  // selected pixel stream toward the tap formatter
  output logic                        pix_valid,
  output logic                        pix_first,
  output logic [TAP_BITS-1:0]         pix_data
);

  // pclk side registers
  logic [15:0]           frames_reg;
  acq_cfg_t              cfg_reg;
  acq_cfg_t              snap_reg;
  logic                  trig_en_reg;
  logic [31:0]           trig_cfg_reg;
  logic [31:0]           drive_reg;
  logic [31:0]           p_delay_reg;
  logic [31:0]           p_high_reg;
  logic [31:0]           p_low_reg;
  logic [31:0]           p_count_reg;
  logic                  busy_reg;
  logic [15:0]           done_cnt_reg;
  logic                  snap_tgl_reg;
  logic [TRIG_LINES-1:0] trig_s1_reg;
  logic [TRIG_LINES-1:0] trig_s2_reg;
  logic [TRIG_LINES-1:0] trig_d_reg;
  logic                  fdone_s1_reg;
  logic                  fdone_s2_reg;
  logic                  fdone_d_reg;
  pulse_state_t          p_state_reg;
  logic [31:0]           p_timer_reg;
  logic [31:0]           p_left_reg;
  logic                  pulse_reg;

  logic                  setup;
  logic                  wr_ctrl;
  logic                  sw_start;
  logic                  sw_stop;
  logic                  trig_hit;
  logic                  start_acq;
  logic                  frame_done;
  logic [TRIG_LINES-1:0] rise;
  logic [TRIG_LINES-1:0] fall;

  // link side registers
  logic                  lrst_s1_reg;
  logic                  lrst_n_reg;
  logic                  act_s1_reg;
  logic                  act_s2_reg;
  logic                  snap_s1_reg;
  logic                  snap_s2_reg;
  logic                  snap_d_reg;
  acq_cfg_t              lcfg_reg;
  cam_enables_t          en_q_reg;
  logic [TAP_BITS-1:0]   data_q_reg;
  logic                  cap_reg;
  logic                  first_reg;
  logic [16:0]           px_cnt_reg;
  logic [16:0]           ln_cnt_reg;
  logic                  fdone_tgl_reg;
  logic                  sel;

  // true when idx lies in the roi nested inside the window, clipped to the window
  function automatic logic in_roi(input logic [16:0] idx, input window_t w, input window_t r);
    logic [16:0] lo;
    logic [16:0] hi;
    logic [16:0] wend;
    lo   = 17'(w.start) + 17'(r.start);
    hi   = lo + 17'(r.count);
    wend = 17'(w.start) + 17'(w.count);
    return (idx >= lo) && (idx < hi) && (idx < wend);
  endfunction : in_roi

  // apb decode, zero wait states
  assign setup    = psel && !penable;
  assign wr_ctrl  = psel && penable && pwrite && (paddr == CTRL_OFS);
  assign sw_start = wr_ctrl && pwdata[CTRL_START_BIT];
  assign sw_stop  = wr_ctrl && pwdata[CTRL_STOP_BIT];

  // pready held high after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= 1'b1;
  end

  // software writable configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frames_reg   <= FRAMES_RST;
      cfg_reg      <= {4{WINDOW_RST}};
      trig_en_reg  <= 1'b0;
      trig_cfg_reg <= '0;
      drive_reg    <= '0;
      p_delay_reg  <= PULSE_RST;
      p_high_reg   <= PULSE_RST;
      p_low_reg    <= PULSE_RST;
      p_count_reg  <= PULSE_RST;
    end
    else if (psel && penable && pwrite)
    begin
      unique case (paddr)
        CTRL_OFS:        trig_en_reg  <= pwdata[CTRL_TRIG_EN_BIT];
        FRAMES_OFS:      frames_reg   <= pwdata[15:0];
        WIN_PX_OFS:      cfg_reg.win_px <= pwdata; // RL2
        WIN_LN_OFS:      cfg_reg.win_ln <= pwdata; // RL3
        ROI_PX_OFS:      cfg_reg.roi_px <= pwdata; // RL4
        ROI_LN_OFS:      cfg_reg.roi_ln <= pwdata; // RL4
        TRIG_CFG_OFS:    trig_cfg_reg <= pwdata;
        TRIG_DRIVE_OFS:  drive_reg    <= pwdata;
        PULSE_DELAY_OFS: p_delay_reg  <= pwdata;
        PULSE_HIGH_OFS:  p_high_reg   <= pwdata;
        PULSE_LOW_OFS:   p_low_reg    <= pwdata;
        PULSE_COUNT_OFS: p_count_reg  <= pwdata;
        default:         ;
      endcase
    end
  end

  // read data and error prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= 1'b0;
      unique case (paddr)
        CTRL_OFS:        prdata <= 32'(trig_en_reg) << CTRL_TRIG_EN_BIT;
        STATUS_OFS:      prdata <= {done_cnt_reg, 14'h0000, (p_state_reg != P_IDLE), busy_reg};
        FRAMES_OFS:      prdata <= {16'h0000, frames_reg};
        WIN_PX_OFS:      prdata <= cfg_reg.win_px;
        WIN_LN_OFS:      prdata <= cfg_reg.win_ln;
        ROI_PX_OFS:      prdata <= cfg_reg.roi_px;
        ROI_LN_OFS:      prdata <= cfg_reg.roi_ln;
        TRIG_CFG_OFS:    prdata <= trig_cfg_reg;
        TRIG_DRIVE_OFS:  prdata <= drive_reg;
        PULSE_DELAY_OFS: prdata <= p_delay_reg;
        PULSE_HIGH_OFS:  prdata <= p_high_reg;
        PULSE_LOW_OFS:   prdata <= p_low_reg;
        PULSE_COUNT_OFS: prdata <= p_count_reg;
        default:
        begin
          prdata  <= '0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // trigger pins pass two flops, third stage holds the previous level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_s1_reg <= '0;
      trig_s2_reg <= '0;
      trig_d_reg  <= '0;
    end
    else
    begin
      trig_s1_reg <= trig_in;
      trig_s2_reg <= trig_s1_reg;
      trig_d_reg  <= trig_s2_reg;
    end
  end

  // per line edge choice and enable
  assign rise     = trig_s2_reg & ~trig_d_reg;
  assign fall     = ~trig_s2_reg & trig_d_reg;
  assign trig_hit = trig_en_reg && |(trig_cfg_reg[TRIG_LINES-1:0] &
                    ((rise & ~trig_cfg_reg[TRIG_FALL_LSB +: TRIG_LINES]) |
                     (fall & trig_cfg_reg[TRIG_FALL_LSB +: TRIG_LINES]))); // RL8 RL9
  assign start_acq = !busy_reg && (sw_start || trig_hit);

  // frame end toggle from the link domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fdone_s1_reg <= 1'b0;
      fdone_s2_reg <= 1'b0;
      fdone_d_reg  <= 1'b0;
    end
    else
    begin
      fdone_s1_reg <= fdone_tgl_reg;
      fdone_s2_reg <= fdone_s1_reg;
      fdone_d_reg  <= fdone_s2_reg;
    end
  end

  assign frame_done = fdone_s2_reg ^ fdone_d_reg;

  // acquisition sequencing; a frame count of zero runs until stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_reg     <= 1'b0;
      done_cnt_reg <= '0;
      snap_reg     <= '0;
      snap_tgl_reg <= 1'b0;
    end
    else if (start_acq)
    begin
      busy_reg     <= 1'b1;
      done_cnt_reg <= '0;
      snap_reg     <= cfg_reg;
      snap_tgl_reg <= ~snap_tgl_reg;
    end
    else if (busy_reg)
    begin
      if (frame_done)
        done_cnt_reg <= done_cnt_reg + 16'h0001;
      if (sw_stop || (frame_done && frames_reg != '0 &&
                      done_cnt_reg + 16'h0001 == frames_reg))
        busy_reg <= 1'b0; // RL7
    end
  end

  // pulse timing: delay, then high and low phases, count of zero repeats forever
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p_state_reg <= P_IDLE;
      p_timer_reg <= '0;
      p_left_reg  <= '0;
      pulse_reg   <= 1'b0;
    end
    else
    begin
      unique case (p_state_reg)
        P_IDLE:
          if (wr_ctrl && pwdata[CTRL_PULSE_BIT])
          begin
            p_state_reg <= P_DELAY;
            p_timer_reg <= p_delay_reg;
            p_left_reg  <= p_count_reg;
          end
        P_DELAY:
          if (p_timer_reg <= 32'h1)
          begin
            p_state_reg <= P_HIGH;
            p_timer_reg <= p_high_reg;
            pulse_reg   <= 1'b1; // RL10
          end
          else
            p_timer_reg <= p_timer_reg - 32'h1;
        P_HIGH:
          if (p_timer_reg <= 32'h1)
          begin
            pulse_reg <= 1'b0;
            if (p_left_reg == 32'h1)
              p_state_reg <= P_IDLE;
            else
            begin
              p_state_reg <= P_LOW;
              p_timer_reg <= p_low_reg;
            end
            if (p_left_reg != '0)
              p_left_reg <= p_left_reg - 32'h1;
          end
          else
            p_timer_reg <= p_timer_reg - 32'h1;
        P_LOW:
          if (p_timer_reg <= 32'h1)
          begin
            p_state_reg <= P_HIGH;
            p_timer_reg <= p_high_reg;
            pulse_reg   <= 1'b1;
          end
          else
            p_timer_reg <= p_timer_reg - 32'h1;
      endcase
    end
  end

  // trigger line drivers: pulse or static level per line
  generate
    for (genvar i = 0; i < TRIG_LINES; i++)
    begin : g_trig_drv
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          trig_out[i] <= 1'b0;
          trig_oe[i]  <= 1'b0;
        end
        else
        begin
          trig_oe[i]  <= drive_reg[i];
          trig_out[i] <= drive_reg[DRIVE_PULSE_LSB + i] ? pulse_reg
                                                       : drive_reg[DRIVE_LEVEL_LSB + i]; // RL10
        end
      end
    end
  endgenerate

  // link domain reset: asynchronous assert, synchronous release
  always_ff @(posedge link_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      lrst_s1_reg <= 1'b0;
      lrst_n_reg  <= 1'b0;
    end
    else
    begin
      lrst_s1_reg <= 1'b1;
      lrst_n_reg  <= lrst_s1_reg;
    end
  end

  // busy level and config snapshot toggle cross into the link domain
  always_ff @(posedge link_clk or negedge lrst_n_reg)
  begin
    if (!lrst_n_reg)
    begin
      act_s1_reg  <= 1'b0;
      act_s2_reg  <= 1'b0;
      snap_s1_reg <= 1'b0;
      snap_s2_reg <= 1'b0;
      snap_d_reg  <= 1'b0;
      lcfg_reg    <= '0;
    end
    else
    begin
      act_s1_reg  <= busy_reg;
      act_s2_reg  <= act_s1_reg;
      snap_s1_reg <= snap_tgl_reg;
      snap_s2_reg <= snap_s1_reg;
      snap_d_reg  <= snap_s2_reg;
      if (snap_s2_reg != snap_d_reg)
        lcfg_reg <= snap_reg; // snapshot stays still while busy
    end
  end

  // camera enables and data sampled once
  always_ff @(posedge link_clk or negedge lrst_n_reg)
  begin
    if (!lrst_n_reg)
    begin
      en_q_reg   <= '0;
      data_q_reg <= '0;
    end
    else
    begin
      en_q_reg   <= cam_en;
      data_q_reg <= cam_data;
    end
  end

  // pixel and line counters restart at the enable edges, saturate, never wrap
  always_ff @(posedge link_clk or negedge lrst_n_reg)
  begin
    if (!lrst_n_reg)
    begin
      px_cnt_reg <= '0;
      ln_cnt_reg <= '0;
    end
    else
    begin
      if (!en_q_reg.lval)
        px_cnt_reg <= '0; // RL2
      else if (en_q_reg.dval && !px_cnt_reg[16])
        px_cnt_reg <= px_cnt_reg + 17'h1; // RL12
      if (!en_q_reg.fval)
        ln_cnt_reg <= '0; // RL3
      else if (en_q_reg.lval && !cam_en.lval && !ln_cnt_reg[16])
        ln_cnt_reg <= ln_cnt_reg + 17'h1; // RL12
    end
  end

  // frame capture decided at frame enable rise; frame end reported by toggle
  always_ff @(posedge link_clk or negedge lrst_n_reg)
  begin
    if (!lrst_n_reg)
    begin
      cap_reg       <= 1'b0;
      fdone_tgl_reg <= 1'b0;
    end
    else if (!en_q_reg.fval && cam_en.fval)
      cap_reg <= act_s2_reg; // RL7 RL8
    else if (en_q_reg.fval && !cam_en.fval && cap_reg)
    begin
      cap_reg       <= 1'b0;
      fdone_tgl_reg <= ~fdone_tgl_reg;
    end
  end

  // window and roi test on every line of every captured frame
  assign sel = cap_reg && en_q_reg.fval && en_q_reg.lval && en_q_reg.dval &&
               in_roi(px_cnt_reg, lcfg_reg.win_px, lcfg_reg.roi_px) &&
               in_roi(ln_cnt_reg, lcfg_reg.win_ln, lcfg_reg.roi_ln); // RL1 RL4 RL5 RL12

  // selected pixel stream toward formatter and dma
  always_ff @(posedge link_clk or negedge lrst_n_reg)
  begin
    if (!lrst_n_reg)
    begin
      pix_valid <= 1'b0;
      pix_first <= 1'b0;
      pix_data  <= '0;
      first_reg <= 1'b0;
    end
    else
    begin
      pix_valid <= sel; // RL6 RL11
      pix_first <= sel && first_reg;
      pix_data  <= data_q_reg;
      if (!en_q_reg.fval && cam_en.fval)
        first_reg <= 1'b1;
      else if (sel)
        first_reg <= 1'b0;
    end
  end

endmodule : acq_roi
`default_nettype wire

// [tb/acq_roi_properties.sv]
// concurrent checks on the acquisition block ports
`timescale 1ns/1ns
`default_nettype none
module acq_roi_properties
  import acq_roi_pkg::*;
#(
  parameter int TAP_BITS = 64
)(
  // register side
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [TRIG_LINES-1:0] trig_oe,
  // link side
  input wire logic                  link_clk,
  input wire cam_enables_t          cam_en,
  input wire logic [TAP_BITS-1:0]   cam_data,
  input wire logic                  pix_valid,
  input wire logic                  pix_first,
  input wire logic [TAP_BITS-1:0]   pix_data
);
  logic [1:0] fv_pipe;
  logic       seen;

  // frame enable delayed to line up with the output stage
  always_ff @(posedge link_clk or negedge presetn)
    if (!presetn)
      fv_pipe <= '0;
    else
      fv_pipe <= {fv_pipe[0], cam_en.fval};

  // set once a pixel of the current frame has left
  always_ff @(posedge link_clk or negedge presetn)
    if (!presetn)
      seen <= 1'b0;
    else
      seen <= fv_pipe[1] & (seen | pix_valid);

  // bus phases
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable && pready;
  endsequence

  AST_READY_ZERO_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup |=> pready)
    else $error("access phase not answered at once");
  AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    apb_access ##0 (paddr > PULSE_COUNT_OFS) |-> pslverr)
    else $error("unmapped access without error");
  AST_ERR_MAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    apb_access ##0 (paddr[1:0] == 2'h0 && paddr <= PULSE_COUNT_OFS) |-> !pslverr)
    else $error("mapped access flagged as error");
  AST_OE_BY_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(trig_oe) |-> $past(psel && penable && pwrite && paddr == TRIG_DRIVE_OFS)
      || $past(psel && penable && pwrite && paddr == TRIG_DRIVE_OFS, 2))
    else $error("line drive enable changed without a write");
  AST_VALID_IN_LINE: assert property (@(posedge link_clk) disable iff (!presetn)
    pix_valid |-> $past(cam_en.fval && cam_en.lval && cam_en.dval, 2))
    else $error("pixel sent that was not active");
  AST_DATA_TWO_LATER: assert property (@(posedge link_clk) disable iff (!presetn)
    pix_valid |-> pix_data == $past(cam_data, 2))
    else $error("pixel data does not match camera data");
  AST_END_AT_FALL: assert property (@(posedge link_clk) disable iff (!presetn)
    !cam_en.fval || !cam_en.lval |-> ##2 !pix_valid)
    else $error("pixel sent after enable fell");
  AST_FIRST_ONCE: assert property (@(posedge link_clk) disable iff (!presetn)
    pix_valid |-> pix_first == !seen)
    else $error("first pixel mark misplaced");
endmodule : acq_roi_properties
`default_nettype wire

// [tb/cam_source.sv]
// camera model sending frames of tagged pixels
`timescale 1ns/1ns
`default_nettype none
module cam_source
  import acq_roi_pkg::*;
(
  // pixel clock from the bench
  input  wire logic        link_clk,
  // enables and tap data
  output var cam_enables_t cam_en,
  output logic [63:0]      cam_data
);
  // idle at time zero
  initial
  begin
    cam_en = '0;
    cam_data = '0;
  end

  // one link cycle; data scrambles whenever no pixel is valid
  task automatic step(input logic [2:0] en, input logic [63:0] d);
    @(posedge link_clk);
    cam_en <= en;
    cam_data <= en[0] ? d : ~cam_data;
  endtask : step

  // one frame of nl lines by np pixels, random stalls when slow
  task automatic frame(input logic [15:0] id, input int nl, input int np, input bit slow);
    for (int l = 0; l < nl; l++)
    begin
      step(3'b100, '0);
      step(3'b100, '0);
      for (int p = 0; p < np; p++)
      begin
        if (slow && $urandom_range(1, 0))
          step(3'b110, '0);
        step(3'b111, {id, 16'h0, 16'(l), 16'(p)});
      end
    end
    step(3'b100, '0);
    repeat (4)
      step(3'b000, '0);
  endtask : frame
endmodule : cam_source
`default_nettype wire

// [tb/acq_roi_tb.sv]
// self-checking bench for the acquisition window and roi block
`timescale 1ns/1ns
`default_nettype none
module acq_roi_tb
  import acq_roi_pkg::*;
  ;
  logic pclk = 1'b0;
  logic link_clk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, pix_valid, pix_first;
  logic [7:0] paddr, trig_in, trig_out, trig_oe, ext_trig;
  logic [31:0] pwdata, prdata, r;
  logic [63:0] cam_data, pix_data;
  cam_enables_t cam_en;
  logic [33:0] bus_q[$];
  logic [64:0] pix_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int wps, wpc, rps, rpc, wls, wlc, rls, rlc, nl, np, ln, hi, rises;

  // clocks and pin resolution
  always #2 pclk = ~pclk;
  always
  begin
    #7 link_clk = ~link_clk;
    #8 link_clk = ~link_clk;
  end
  assign trig_in = (trig_oe & trig_out) | (~trig_oe & ext_trig);

  acq_roi acq_roi_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .trig_in, .trig_out, .trig_oe, .link_clk, .cam_en,
    .cam_data, .pix_valid, .pix_first, .pix_data);
  cam_source cam_source_i (.link_clk, .cam_en, .cam_data);

  // comparisons
  task automatic cmp_bus(input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_bus
  task automatic cmp_pix(input logic [64:0] e, input logic [64:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_pix

  // one apb transfer; e holds {check, error, read data}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    bus_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h2_0000_0000);
  endtask : wr
  task automatic busy_is(input logic b);
    apb(1'b0, STATUS_OFS, 32'h0, 34'h0);
    cmp_bus({32'h0, b}, {32'h0, r[0]});
  endtask : busy_is

  // note the pixels a frame should yield
  function automatic bit pick(int i, int ws, int wc, int rs, int rc);
    return i >= ws + rs && i < ws + wc && i < ws + rs + rc;
  endfunction : pick
  task automatic expect_frame(input logic [15:0] id);
    bit f;
    f = 1'b1;
    for (int l = 0; l < nl; l++)
      for (int p = 0; p < np; p++)
        if (pick(l, wls, wlc, rls, rlc) && pick(p, wps, wpc, rps, rpc))
        begin
          pix_q.push_back({f, id, 16'h0, 16'(l), 16'(p)});
          f = 1'b0;
        end
  endtask : expect_frame

  // software start of nf frames, then one frame that must be dropped
  task automatic run_sw(input int nf, input bit slow);
    wr(WIN_PX_OFS, {16'(wpc), 16'(wps)});
    wr(WIN_LN_OFS, {16'(wlc), 16'(wls)});
    wr(ROI_PX_OFS, {16'(rpc), 16'(rps)});
    wr(ROI_LN_OFS, {16'(rlc), 16'(rls)});
    wr(FRAMES_OFS, 32'(nf));
    wr(CTRL_OFS, 32'h1);
    repeat (30) @(posedge pclk);
    busy_is(1'b1);
    for (int k = 1; k <= nf; k++)
    begin
      expect_frame(16'(k));
      cam_source_i.frame(16'(k), nl, np, slow);
    end
    for (int n = 0; n < 100 && r[0] !== 1'b0; n++)
      apb(1'b0, STATUS_OFS, 32'h0, 34'h0);
    apb(1'b0, STATUS_OFS, 32'h0, {2'b10, 16'(nf), 16'h0});
    cam_source_i.frame(16'h00ee, nl, np, slow);
  endtask : run_sw

  // compare completed transfers with their notes
  always @(posedge pclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
      if (bus_q.size() > 0 && bus_q[0][33])
        cmp_bus(33'(bus_q.pop_front()), {pslverr, pwrite ? 32'h0 : prdata});
      else
        void'(bus_q.pop_front());

  // compare every streamed pixel with the oldest note
  always @(posedge link_clk)
    if (pix_valid === 1'b1)
      cmp_pix(pix_q.size() ? pix_q.pop_front() : '1, {pix_first, pix_data});

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_trig} = '0;
    void'($urandom(32'hd940416b));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped places, ignored status write
    for (int i = 0; i < 15; i++)
      apb(1'b0, 8'(i * 4), 32'h0, {1'b1, i > 12, i == 2 ? 32'(FRAMES_RST) :
        (i > 2 && i < 7) ? WINDOW_RST : (i > 8 && i < 13) ? PULSE_RST : 32'h0});
    apb(1'b1, STATUS_OFS, 32'hffff_ffff, 34'h2_0000_0000);
    apb(1'b1, 8'h3c, 32'hffff_ffff, 34'h3_0000_0000);
    apb(1'b0, STATUS_OFS, 32'h0, 34'h2_0000_0000);
    // full window with counts past the frame, then random nested regions
    {wps, wpc, rps, rpc, wls, wlc, rls, rlc} = {4{32'd0, 32'd65535}};
    {nl, np} = {32'd3, 32'd5};
    run_sw(1, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      {wps, rps, wls, rls} = {$urandom_range(3, 0), $urandom_range(3, 0),
        $urandom_range(2, 0), $urandom_range(2, 0)};
      {wpc, rpc, wlc, rlc} = {$urandom_range(8, 1), $urandom_range(6, 1),
        $urandom_range(5, 1), $urandom_range(4, 1)};
      {nl, np} = {$urandom_range(6, 3), $urandom_range(10, 6)};
      run_sw(k + 2, 1'b1);
    end
    // trigger start on each edge choice, wrong edge first
    for (int pol = 0; pol < 2; pol++)
    begin
      ln = $urandom_range(7, 0);
      ext_trig[ln] <= !pol;
      wr(TRIG_CFG_OFS, (32'(pol) << (ln + 8)) | (32'h1 << ln));
      wr(CTRL_OFS, 32'h4);
      @(posedge pclk) ext_trig[ln] <= pol[0];
      repeat (10) @(posedge pclk);
      busy_is(1'b0);
      ext_trig[ln] <= !pol;
      repeat (10) @(posedge pclk);
      busy_is(1'b1);
      wr(CTRL_OFS, 32'h2);
      busy_is(1'b0);
    end
    // pulse train on line 7, static high level on line 5
    wr(PULSE_DELAY_OFS, 32'h8);
    wr(PULSE_HIGH_OFS, 32'h3);
    wr(PULSE_LOW_OFS, 32'h2);
    wr(PULSE_COUNT_OFS, 32'h3);
    wr(TRIG_DRIVE_OFS, 32'h0020_80a0);
    wr(CTRL_OFS, 32'h8);
    apb(1'b0, STATUS_OFS, 32'h0, 34'h2_0000_0002);
    {hi, rises, ln} = '0;
    // count high cycles and rising edges of the train, sampled mid cycle
    repeat (40)
    begin
      @(negedge pclk);
      hi += int'(trig_out[7]);
      rises += int'(trig_out[7] && !ln[0]);
      ln = int'(trig_out[7]);
    end
    apb(1'b0, STATUS_OFS, 32'h0, 34'h2_0000_0000);
    cmp_bus(33'd9, 33'(hi));
    cmp_bus(33'd3, 33'(rises));
    cmp_bus(33'h0a0, {25'h0, trig_oe});
    cmp_bus(33'h1, {32'h0, trig_out[5]});
    stop_test();
  end

  // cut a hung run short
  initial
  begin
    #300000;
    fail_count++;
    stop_test();
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
endmodule : acq_roi_tb

bind acq_roi acq_roi_properties #(.TAP_BITS(TAP_BITS)) acq_roi_properties_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .trig_oe, .link_clk,
  .cam_en, .cam_data, .pix_valid, .pix_first, .pix_data);
`default_nettype wire
